// ### shared/ccr_pkg.sv
// Package for the comparator C/D configuration register bank.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package ccr_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [15:0] CCR_IDX_CONFIG    = 16'hA039;
  localparam logic [15:0] CCR_IDX_THRESHOLD = 16'hA03A;
  localparam logic [15:0] CCR_IDX_IRQ_STAT  = 16'hA03D;
  localparam logic [15:0] CCR_IDX_IRQ_MASK  = 16'hA03E;
  localparam logic [17:0] CCR_ADDR_CONFIG    = {CCR_IDX_CONFIG, 2'b00};
  localparam logic [17:0] CCR_ADDR_THRESHOLD = {CCR_IDX_THRESHOLD, 2'b00};
  localparam logic [17:0] CCR_ADDR_IRQ_STAT  = {CCR_IDX_IRQ_STAT, 2'b00};
  localparam logic [17:0] CCR_ADDR_IRQ_MASK  = {CCR_IDX_IRQ_MASK, 2'b00};

  // Reset values.
  localparam logic [7:0] CCR_RST_CONFIG    = 8'h00;
  localparam logic [7:0] CCR_RST_THRESHOLD = 8'h00;
  localparam logic [1:0] CCR_RST_IRQ       = 2'h0;
  localparam logic [1:0] CCR_RST_MASK      = 2'h3;

  // Field positions inside the configuration register.
  localparam int CCR_C_ENABLE     = 7;
  localparam int CCR_C_THR_SEL    = 6;
  localparam int CCR_C_IRQ_ENABLE = 5;
  localparam int CCR_C_INVERT     = 4;
  localparam int CCR_D_ENABLE     = 3;
  localparam int CCR_D_THR_SEL    = 2;
  localparam int CCR_D_IRQ_ENABLE = 1;
  localparam int CCR_D_INVERT     = 0;

  // Status/mask bit positions.
  localparam int CCR_IRQ_C = 1;
  localparam int CCR_IRQ_D = 0;

  // Bus responses.
  localparam logic [1:0] CCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CCR_RESP_SLVERR = 2'h2;

  // Per-comparator control bundle.
  typedef struct packed {
    logic enable;
    logic threshold_select;
    logic irq_enable;
    logic invert;
  } ccr_comp_ctl_t;

endpackage

// ### core/ccr_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes the input comes from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module ccr_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Data.
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;

  // Elaboration check: at least one bit must be carried.
  if (WIDTH < 1) begin : g_width_check
    $error("ccr_sync: WIDTH must be at least 1");
  end

  // A bit changes only once stages two and three agree.
  always_comb begin
    nxt_out = out_ff;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_out[i] = s3_ff[i];
      end
    end
  end

  // Register the three stages and the filtered value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      s2_ff   <= '0;
      s3_ff   <= '0;
      out_ff  <= '0;
    end else begin
      meta_ff <= async_i;
      s2_ff   <= meta_ff;
      s3_ff   <= s2_ff;
      out_ff  <= nxt_out;
    end
  end

  assign sync_o = out_ff;

endmodule
`default_nettype wire

// ### core/ccr_comp_path.sv
// Output path of one comparator: gating, polarity, toggle detect, threshold pick.
// Assumes a synchronised raw comparator level on the system clock.
`timescale 1ns/1ps
`default_nettype none
module ccr_comp_path
  import ccr_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Control and levels.
  input  wire ccr_comp_ctl_t ctl_i,
  input  wire logic          raw_i,
  // Results.
  output logic               live_o,
  output logic               toggle_o,
  output logic               use_external_o
);

  logic live_ff;
  logic nxt_live;
  logic prev_ff;
  logic nxt_prev;

  // Polarity inversion applied.
  // Real-time output is forced low from the cycle after the comparator is disabled.
  always_comb begin
    nxt_live = ctl_i.enable & (raw_i ^ ctl_i.invert);
    nxt_prev = live_ff;
  end

  // Register the live output and its previous value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      live_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      live_ff <= nxt_live;
      prev_ff <= nxt_prev;
    end
  end

  assign live_o   = live_ff;
  assign toggle_o = ctl_i.enable & (live_ff ^ prev_ff);
  assign use_external_o = ctl_i.threshold_select;

endmodule
`default_nettype wire

// ### core/ccr_top.sv
// Register bank for comparators C and D behind an AXI4-Lite slave.
// Assumes raw comparator levels arrive asynchronously and the DAC takes the code directly.
//
// Functional notes
// - Config register, bits 7:4 comparator C, 3:0 comparator D, reset zero.
// - Threshold-select one routes the external threshold to comparator D.
// - Comparator D flag reaches the interrupt only with its enable set.
// - Polarity zero passes the output, polarity one inverts it.
// - Threshold register, eight bits, reset zero, drives the DAC directly.
// - Code zero means 0 V, all ones means 1.5 V full scale.
// - Toggle of an enabled comparator sets a sticky flag until cleared.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ccr_top
  import ccr_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // Clock and reset.
  input  wire logic              CORE_CLK_I,
  input  wire logic              SYS_RST_I,
  // AXI4-Lite write address.
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  // AXI4-Lite write data.
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  // AXI4-Lite write response.
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  // AXI4-Lite read address.
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  // AXI4-Lite read data.
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  // Analog side.
  input  wire logic              COMP_C_RAW_I,
  input  wire logic              COMP_D_RAW_I,
  output logic [7:0]             INTERNAL_THRESHOLD_ZERO_O,
  output logic                   COMP_C_USE_EXTERNAL_O,
  output logic                   COMP_D_USE_EXTERNAL_O,
  output logic                   COMP_C_ENABLE_O,
  output logic                   COMP_D_ENABLE_O,
  output logic                   COMP_C_LIVE_O,
  output logic                   COMP_D_LIVE_O,
  // Interrupt.
  output logic                   IRQ_O
);

  typedef enum logic [2:0] {
    CCR_W_IDLE = 3'b001,
    CCR_W_WAIT = 3'b010,
    CCR_W_RESP = 3'b100
  } ccr_wstate_t;

  // Write channel state.
  ccr_wstate_t       wstate_ff;
  ccr_wstate_t       nxt_wstate;
  logic              aw_have_ff;
  logic              nxt_aw_have;
  logic              w_have_ff;
  logic              nxt_w_have;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [ADDR_W-1:0] nxt_awaddr;
  logic [31:0]       wdata_ff;
  logic [31:0]       nxt_wdata;
  logic [3:0]        wstrb_ff;
  logic [3:0]        nxt_wstrb;
  logic [1:0]        bresp_ff;
  logic [1:0]        nxt_bresp;
  logic              do_write;
  // Read channel state.
  logic              rvalid_ff;
  logic              nxt_rvalid;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic [1:0]        rresp_ff;
  logic [1:0]        nxt_rresp;
  // Software-visible registers.
  logic [7:0]        config_ff;
  logic [7:0]        nxt_config;
  logic [7:0]        thresh_ff;
  logic [7:0]        nxt_thresh;
  logic [1:0]        stat_ff;
  logic [1:0]        nxt_stat;
  logic [1:0]        mask_ff;
  logic [1:0]        nxt_mask;
  // Comparator paths.
  logic [1:0]        raw_sync;
  logic              tog_c;
  logic              tog_d;
  ccr_comp_ctl_t     ctl_c;
  ccr_comp_ctl_t     ctl_d;

  // Elaboration check: the decode needs the full 18-bit register window.
  if (ADDR_W < 18) begin : g_addr_w_check
    $error("ccr_top: ADDR_W must be at least 18");
  end

  // Known register decode shared by read and write paths.
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    logic [17:0] w;
    w = a[17:0];
    addr_known = (a == ADDR_W'(w)) &&
                 (w == CCR_ADDR_CONFIG || w == CCR_ADDR_THRESHOLD ||
                  w == CCR_ADDR_IRQ_STAT || w == CCR_ADDR_IRQ_MASK);
  endfunction

  // Control bundles unpacked from the configuration register.
  assign ctl_c = config_ff[CCR_C_ENABLE:CCR_C_INVERT];
  assign ctl_d = config_ff[CCR_D_ENABLE:CCR_D_INVERT];

  // Synchronise the raw comparator levels.
  ccr_sync #(.WIDTH(2)) u_sync (
    .clk_i   (CORE_CLK_I),
    .rst_i   (SYS_RST_I),
    .async_i ({COMP_C_RAW_I, COMP_D_RAW_I}),
    .sync_o  (raw_sync)
  );

  // Comparator C output path.
  ccr_comp_path u_path_c (
    .clk_i           (CORE_CLK_I),
    .rst_i           (SYS_RST_I),
    .ctl_i           (ctl_c),
    .raw_i           (raw_sync[1]),
    .live_o          (COMP_C_LIVE_O),
    .toggle_o        (tog_c),
    .use_external_o  (COMP_C_USE_EXTERNAL_O)
  );

  // Comparator D output path.
  ccr_comp_path u_path_d (
    .clk_i           (CORE_CLK_I),
    .rst_i           (SYS_RST_I),
    .ctl_i           (ctl_d),
    .raw_i           (raw_sync[0]),
    .live_o          (COMP_D_LIVE_O),
    .toggle_o        (tog_d),
    .use_external_o  (COMP_D_USE_EXTERNAL_O)
  );

  // Write channel: accept address and data in either order, then respond.
  // Holding both halves for a cycle before the commit keeps the decode off the bus inputs.
  always_comb begin
    nxt_wstate  = wstate_ff;
    nxt_aw_have = aw_have_ff;
    nxt_w_have  = w_have_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bresp   = bresp_ff;
    do_write    = 1'b0;
    case (wstate_ff)
      CCR_W_IDLE, CCR_W_WAIT: begin
        if (S_AXI_AWVALID_I && !aw_have_ff) begin
          nxt_aw_have = 1'b1;
          nxt_awaddr  = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && !w_have_ff) begin
          nxt_w_have = 1'b1;
          nxt_wdata  = S_AXI_WDATA_I;
          nxt_wstrb  = S_AXI_WSTRB_I;
        end
        nxt_wstate = CCR_W_WAIT;
        // Both halves held: commit now and raise the response next cycle.
        if (aw_have_ff && w_have_ff) begin
          do_write    = 1'b1;
          nxt_bresp   = addr_known(awaddr_ff) ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
          nxt_aw_have = 1'b0;
          nxt_w_have  = 1'b0;
          nxt_wstate  = CCR_W_RESP;
        end
      end
      CCR_W_RESP: begin
        if (S_AXI_BREADY_I) begin
          nxt_wstate = CCR_W_IDLE;
        end
      end
      default: begin
        nxt_wstate = CCR_W_IDLE;
      end
    endcase
  end

  // Readies drop while a half is held or the response waits, so nothing is lost.
  assign S_AXI_AWREADY_O = (wstate_ff != CCR_W_RESP) && !aw_have_ff;
  assign S_AXI_WREADY_O  = (wstate_ff != CCR_W_RESP) && !w_have_ff;
  assign S_AXI_BVALID_O  = (wstate_ff == CCR_W_RESP);
  assign S_AXI_BRESP_O   = bresp_ff;

  // Register updates, status set and clear.
  // A write that names no register, or has its low strobe clear, changes nothing.
  always_comb begin
    nxt_config = config_ff;
    nxt_thresh = thresh_ff;
    nxt_mask   = mask_ff;
    nxt_stat   = stat_ff;
    if (do_write && wstrb_ff[0] && addr_known(awaddr_ff)) begin
      case (awaddr_ff[17:0])
        CCR_ADDR_CONFIG:    nxt_config = wdata_ff[7:0];
        CCR_ADDR_THRESHOLD: nxt_thresh = wdata_ff[7:0];
        CCR_ADDR_IRQ_MASK:  nxt_mask   = wdata_ff[1:0];
        CCR_ADDR_IRQ_STAT:  nxt_stat   = stat_ff & ~wdata_ff[1:0];
        default:            nxt_stat   = stat_ff;
      endcase
    end
    // Setting after the clear lets an event in the clearing cycle survive it.
    // Sticky flag set wins.
    nxt_stat[CCR_IRQ_C] = nxt_stat[CCR_IRQ_C] | tog_c;
    nxt_stat[CCR_IRQ_D] = nxt_stat[CCR_IRQ_D] | tog_d;
  end

  // Read channel: one read outstanding, answered one cycle after the handshake.
  // Data are captured at the address handshake and held until taken.
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rvalid_ff && S_AXI_RREADY_I) begin
      nxt_rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = addr_known(S_AXI_ARADDR_I) ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
      case (S_AXI_ARADDR_I[17:0])
        CCR_ADDR_CONFIG:    nxt_rdata = {24'h000000, config_ff};
        CCR_ADDR_THRESHOLD: nxt_rdata = {24'h000000, thresh_ff};
        CCR_ADDR_IRQ_STAT:  nxt_rdata = {28'h0000000, COMP_C_LIVE_O, COMP_D_LIVE_O, stat_ff};
        CCR_ADDR_IRQ_MASK:  nxt_rdata = {30'h0, mask_ff};
        default:            nxt_rdata = 32'h00000000;
      endcase
      // Any address above the register window reads as zero.
      if (S_AXI_ARADDR_I != ADDR_W'(S_AXI_ARADDR_I[17:0])) begin
        nxt_rdata = 32'h00000000;
      end
    end
  end

  assign S_AXI_ARREADY_O = !rvalid_ff;
  assign S_AXI_RVALID_O  = rvalid_ff;
  assign S_AXI_RDATA_O   = rdata_ff;
  assign S_AXI_RRESP_O   = rresp_ff;

  // Register all state.
  // Every register takes its reset value on a synchronous reset.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      wstate_ff  <= CCR_W_IDLE;
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bresp_ff   <= CCR_RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= CCR_RESP_OKAY;
      config_ff  <= CCR_RST_CONFIG;
      thresh_ff  <= CCR_RST_THRESHOLD;
      stat_ff    <= CCR_RST_IRQ;
      mask_ff    <= CCR_RST_MASK;
    end else begin
      wstate_ff  <= nxt_wstate;
      aw_have_ff <= nxt_aw_have;
      w_have_ff  <= nxt_w_have;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      config_ff  <= nxt_config;
      thresh_ff  <= nxt_thresh;
      stat_ff    <= nxt_stat;
      mask_ff    <= nxt_mask;
    end
  end

  // Code 00 is 0 V, FF is 1.5 V.
  assign INTERNAL_THRESHOLD_ZERO_O = thresh_ff;
  // Enables go straight to the analog bias of each comparator.
  assign COMP_C_ENABLE_O = ctl_c.enable;
  assign COMP_D_ENABLE_O = ctl_d.enable;

  // The interrupt needs the flag, the comparator's interrupt-enable bit and the mask bit.
  // Flag gated by irq enable.
  assign IRQ_O = (stat_ff[CCR_IRQ_D] & ctl_d.irq_enable & mask_ff[CCR_IRQ_D]) |
                 (stat_ff[CCR_IRQ_C] & ctl_c.irq_enable & mask_ff[CCR_IRQ_C]);

endmodule
`default_nettype wire

// ### verification/ccr_top_props.sv
// Concurrent checks on the comparator C/D register bank top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ccr_top_props #(
  parameter int ADDR_W = 18
) (
  // Clock and reset.
  input  wire logic        CORE_CLK_I,
  input  wire logic        SYS_RST_I,
  // Bus handshakes.
  input  wire logic        S_AXI_AWVALID_I,
  input  wire logic        S_AXI_AWREADY_O,
  input  wire logic        S_AXI_WVALID_I,
  input  wire logic        S_AXI_WREADY_O,
  input  wire logic [1:0]  S_AXI_BRESP_O,
  input  wire logic        S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic        S_AXI_ARVALID_I,
  input  wire logic        S_AXI_ARREADY_O,
  input  wire logic [31:0] S_AXI_RDATA_O,
  input  wire logic        S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // Analog side.
  input  wire logic [7:0]  INTERNAL_THRESHOLD_ZERO_O,
  input  wire logic        COMP_C_ENABLE_O,
  input  wire logic        COMP_D_ENABLE_O,
  input  wire logic        COMP_C_LIVE_O,
  input  wire logic        COMP_D_LIVE_O,
  input  wire logic        IRQ_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  property p_reset_out;
    $fell(SYS_RST_I) |-> INTERNAL_THRESHOLD_ZERO_O == 8'h00 && !IRQ_O && !COMP_D_LIVE_O;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
  property p_dac_write;
    !$stable(INTERNAL_THRESHOLD_ZERO_O) |-> $rose(S_AXI_BVALID_O);
  endproperty
  a_dac_write: assert property (p_dac_write) else $error("DAC code moved without a write");
  property p_d_off;
    !COMP_D_ENABLE_O && !$past(COMP_D_ENABLE_O) |-> !COMP_D_LIVE_O;
  endproperty
  a_d_off: assert property (p_d_off) else $error("D live output high while disabled");
  property p_c_off;
    !COMP_C_ENABLE_O && !$past(COMP_C_ENABLE_O) |-> !COMP_C_LIVE_O;
  endproperty
  a_c_off: assert property (p_c_off) else $error("C live output high while disabled");
  property p_b_hold;
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_r_lat;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O ##0 S_AXI_RDATA_O[31:8] == 24'h000000;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late or too wide");
  property p_w_lat;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
      |-> ##[1:3] S_AXI_BVALID_O;
  endproperty
  a_w_lat: assert property (p_w_lat) else $error("write response late");
  property p_busy;
    S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O;
  endproperty
  a_busy: assert property (p_busy) else $error("new write taken during response");
endmodule

bind ccr_top ccr_top_props #(.ADDR_W(ADDR_W)) ccr_top_props_inst (
  .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I), .INTERNAL_THRESHOLD_ZERO_O(INTERNAL_THRESHOLD_ZERO_O),
  .COMP_C_ENABLE_O(COMP_C_ENABLE_O), .COMP_D_ENABLE_O(COMP_D_ENABLE_O),
  .COMP_C_LIVE_O(COMP_C_LIVE_O), .COMP_D_LIVE_O(COMP_D_LIVE_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ### verification/ccr_top_tb.sv
// Self-checking bench for the comparator C/D register bank.
// Assumes the bench is the only bus master and drives both raw comparator levels.
`timescale 1ns/1ps
`default_nettype none
module ccr_top_tb;
  import ccr_pkg::*;
  logic        clk = 1'b0, rst = 1'b1;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic        c_raw = 0, d_raw = 0, c_ext, d_ext, c_en, d_en, c_live, d_live;
  logic [7:0]  dac;
  int          n_errors = 0, n_checks = 0;

  // Clock of 4 ns period.
  always #2 clk = ~clk;

  ccr_top ccr_top_inst (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .COMP_C_RAW_I(c_raw), .COMP_D_RAW_I(d_raw), .INTERNAL_THRESHOLD_ZERO_O(dac),
    .COMP_C_USE_EXTERNAL_O(c_ext), .COMP_D_USE_EXTERNAL_O(d_ext), .COMP_C_ENABLE_O(c_en),
    .COMP_D_ENABLE_O(d_en), .COMP_C_LIVE_O(c_live), .COMP_D_LIVE_O(d_live), .IRQ_O(irq));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus write; address and data offered together, each released when taken.
  // The response ready may be held back for hold cycles so that the response waits.
  task automatic wr(input logic [17:0] a, input logic [31:0] d,
                    input logic [1:0] er = CCR_RESP_OKAY, input int hold = 0);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (hold == 0);
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n >= hold && n < 100 && !bready) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 100);
    bready <= 1'b0;
    chk({31'h0, bvalid}, 32'h1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  // One bus read, checking data and response; the data ready may be held back.
  task automatic rc(input logic [17:0] a, input logic [31:0] exp,
                    input logic [1:0] er = CCR_RESP_OKAY, input int hold = 0);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (hold == 0);
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n >= hold && n < 100 && !rready) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 100);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic t_reset();
    rc(CCR_ADDR_CONFIG, 32'h0);
    rc(CCR_ADDR_THRESHOLD, 32'h0);
    rc(CCR_ADDR_IRQ_STAT, 32'h0);
    rc(CCR_ADDR_IRQ_MASK, 32'h3);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask

  // Each of four field patterns reaches the register and the enable and threshold-select outputs.
  task automatic t_config();
    logic [7:0] v [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
    foreach (v[i]) begin
      wr(CCR_ADDR_CONFIG, {24'hC3C3C3, v[i]});
      rc(CCR_ADDR_CONFIG, {24'h0, v[i]});
      chk({28'h0, c_en, c_ext, d_en, d_ext}, {28'h0, v[i][7:6], v[i][3:2]});
    end
    $display("test config done");
  endtask

  // Threshold codes at both ends of the scale drive the DAC unchanged.
  task automatic t_threshold();
    logic [7:0] v [4] = '{8'hFF, 8'h80, 8'h01, 8'h00};
    foreach (v[i]) begin
      wr(CCR_ADDR_THRESHOLD, {24'h0, v[i]});
      rc(CCR_ADDR_THRESHOLD, {24'h0, v[i]});
      chk({24'h0, dac}, {24'h0, v[i]});
    end
    $display("test threshold done");
  endtask

  // Polarity passes or inverts the live level; disabling forces it low.
  task automatic t_polarity();
    wr(CCR_ADDR_CONFIG, 32'h88);
    c_raw <= 1'b1;
    repeat (12) @(posedge clk);
    chk({30'h0, c_live, d_live}, 32'h2);
    wr(CCR_ADDR_CONFIG, 32'h99);
    repeat (12) @(posedge clk);
    chk({30'h0, c_live, d_live}, 32'h1);
    wr(CCR_ADDR_CONFIG, 32'h00);
    repeat (12) @(posedge clk);
    chk({30'h0, c_live, d_live}, 32'h0);
    wr(CCR_ADDR_IRQ_STAT, 32'h3);
    rc(CCR_ADDR_IRQ_STAT, 32'h0);
    $display("test polarity done");
  endtask

  // Toggles set sticky flags; enable and mask gate the interrupt.
  task automatic t_irq();
    wr(CCR_ADDR_CONFIG, 32'h0A);
    repeat (12) @(posedge clk);
    wr(CCR_ADDR_IRQ_STAT, 32'h3);
    chk({31'h0, irq}, 32'h0);
    d_raw <= 1'b1;
    repeat (12) @(posedge clk);
    rc(CCR_ADDR_IRQ_STAT, 32'h5);
    chk({31'h0, irq}, 32'h1);
    wr(CCR_ADDR_IRQ_MASK, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(CCR_ADDR_IRQ_MASK, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(CCR_ADDR_IRQ_STAT, 32'h1);
    rc(CCR_ADDR_IRQ_STAT, 32'h4);
    chk({31'h0, irq}, 32'h0);
    wr(CCR_ADDR_CONFIG, 32'h08);
    d_raw <= 1'b0;
    repeat (30) @(posedge clk);
    rc(CCR_ADDR_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(CCR_ADDR_CONFIG, 32'hA0);
    repeat (12) @(posedge clk);
    wr(CCR_ADDR_IRQ_STAT, 32'h3);
    c_raw <= 1'b0;
    repeat (12) @(posedge clk);
    rc(CCR_ADDR_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h1);
    $display("test irq done");
  endtask

  // Unmapped place answers with an error and changes nothing.
  task automatic t_unmapped();
    wr(18'h00000, 32'hFF, CCR_RESP_SLVERR);
    rc(18'h00000, 32'h0, CCR_RESP_SLVERR);
    rc(CCR_ADDR_CONFIG, 32'hA0);
    $display("test unmapped done");
  endtask

  // Late response readies keep answers standing; a clear low strobe changes nothing.
  task automatic t_hold();
    wr(CCR_ADDR_THRESHOLD, 32'h3C, CCR_RESP_OKAY, 4);
    rc(CCR_ADDR_THRESHOLD, 32'h3C, CCR_RESP_OKAY, 3);
    chk({24'h0, dac}, 32'h3C);
    wr(CCR_ADDR_THRESHOLD, 32'h00);
    wstrb <= 4'hE;
    wr(CCR_ADDR_CONFIG, 32'h55);
    wstrb <= 4'hF;
    rc(CCR_ADDR_CONFIG, 32'hA0);
    $display("test hold done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence after twelve cycles of reset.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_threshold();
    t_polarity();
    t_irq();
    t_unmapped();
    t_hold();
    conclude();
  end

  // Watchdog well past the expected run of under two thousand cycles.
  initial begin
    #(4 * 20000);
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
